// *** pkg/spw_regs.svh ***
// register offsets, field positions, reset values and protocol constants of the six-channel pwm block
`ifndef SPW_REGS_SVH
`define SPW_REGS_SVH
`define SPW_REG_CTRL 8'h00
`define SPW_REG_SLOTDIV 8'h04
`define SPW_REG_GPOEN 8'h08
`define SPW_REG_GPOMODE 8'h0C
`define SPW_REG_STATUS 8'h10
`define SPW_REG_PWM_BASE 8'h20
`define SPW_CTRL_INV_BIT 0
`define SPW_CLK_HZ 20000000
`define SPW_FRAME_HZ 200
`define SPW_SLOTS 128
`define SPW_SLOTDIV_RST (`SPW_CLK_HZ / (`SPW_SLOTS * `SPW_FRAME_HZ) - 1)
`define SPW_SLOT_MAX 7'h7F
`define SPW_ADDR_FIXED 6'h1C
`define SPW_CMD_PTR_TAG 5'h1D
`define SPW_CO_BIT 7
`define SPW_BIT_LAST 3'h7
`define SPW_RESP_OKAY 2'h0
`define SPW_RESP_SLVERR 2'h2
`define SPW_SYNC_RST 3'h7
`endif

// *** pkg/spw_pkg.sv ***
// types shared by the six-channel pwm block
package spw_pkg;
    typedef enum logic [1:0] {
        SPW_IDLE = 2'b00,
        SPW_RX = 2'b01,
        SPW_ACK = 2'b10
    } spw_state_type;
    typedef enum logic [1:0] {
        SPW_PH_ADDR = 2'b00,
        SPW_PH_CTRL = 2'b01,
        SPW_PH_DATA = 2'b10
    } spw_phase_type;
    typedef enum logic [1:0] {
        SPW_RT_CMD = 2'b00,
        SPW_RT_RAM = 2'b01,
        SPW_RT_PWM = 2'b10,
        SPW_RT_NONE = 2'b11
    } spw_route_type;
    typedef enum logic [1:0] {
        SPW_GM_LOW = 2'b00,
        SPW_GM_HIGH = 2'b01,
        SPW_GM_PWM = 2'b10,
        SPW_GM_RSVD = 2'b11
    } spw_gpo_mode_type;
endpackage : spw_pkg

// *** verilog/spw_top.sv ***
// six-channel pwm generator with write-only two-wire slave and axi4-lite control
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "spw_regs.svh"
// Function
// RQ1: six independent pwm channels with own values
// RQ2: pwm data byte stored at pointer register
// RQ3: pointer increments per byte, wraps after last
// RQ4: enabled output replaces the segment signal
// RQ5: output mode constant one, zero or pwm
// RQ6: frame of 128 slots, high for value
// RQ7: zero all low, 127 one low slot
// RQ8: inversion bit inverts every channel waveform
// RQ9: plain mode: all rise at frame start
// RQ10: inverted: high 128 minus value, fall together
// RQ11: control byte bit 7 flags more control
// RQ12: bits 6:5 route to command, ram, pwm
// RQ13: new control byte switches routing mid access
// RQ14: sda edge with scl high is start/stop
// RQ15: any byte count, each byte then ack
// RQ16: addressed device pulls sda low for ack
// RQ17: slave receiver only, never transmits data
// RQ18: address 011100, bit1 vs select pin, rw
// RQ19: mismatched address ignored until next start
// RQ20: master ends with stop or repeated start
// RQ21: route 11 bytes acked and discarded
// RQ22: slot tick from programmed frame rate
// RQ23: new values take effect at frame boundary
module spw_top #(
    parameter int NCH = 6,
    parameter logic [15:0] SLOTDIV_RST = 16'(`SPW_SLOTDIV_RST)
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin,
    // command and ram byte streams to the lcd part
    output logic cmd_valid,
    output logic [7:0] cmd_data,
    output logic ram_valid,
    output logic [7:0] ram_data,
    // shared segment pins
    input wire logic [NCH-1:0] segment_in,
    output logic [NCH-1:0] segment_pins,
    output logic [NCH-1:0] aux_output_pins
);
    import spw_pkg::*;

    if (NCH < 1 || NCH > 8) begin : g_chk
        $error("spw_top: NCH must be 1 to 8");
    end

    // pin synchronisers: bit0 scl, bit1 sda, bit2 address select
    logic [2:0] sync1_q, sync2_q, sync3_q, lvl_q, lvl;
    // a level moves once two stages agree, which also rejects one-cycle glitches; no extra
    // register here, or the ack would be released after the master raises scl again
    assign lvl = (sync3_q & ~(sync2_q ^ sync3_q)) | (lvl_q & (sync2_q ^ sync3_q));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= `SPW_SYNC_RST;
            sync2_q <= `SPW_SYNC_RST;
            sync3_q <= `SPW_SYNC_RST;
            lvl_q <= `SPW_SYNC_RST;
        end else begin
            sync1_q <= {address_select_pin, sda_in, scl_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            lvl_q <= lvl;
        end
    end

    logic scl, sda, scl_prev, sda_prev, scl_rise, scl_fall, start_det, stop_det;
    assign scl = lvl[0];
    assign sda = lvl[1];
    assign scl_prev = lvl_q[0];
    assign sda_prev = lvl_q[1];
    assign scl_rise = scl && !scl_prev;
    assign scl_fall = !scl && scl_prev;
    assign start_det = scl && scl_prev && sda_prev && !sda; // [RQ14]
    assign stop_det = scl && scl_prev && !sda_prev && sda; // [RQ14]

    // bit-level receiver
    spw_state_type state_q;
    spw_phase_type phase_q;
    spw_route_type route_q;
    logic [2:0] cnt_q;
    logic [6:0] shift_q;
    logic ack_en_q, ack_rise_q, ack_drive_q, more_q, addressed_q;
    logic [7:0] rx_byte;
    logic byte_done, addr_match;
    assign rx_byte = {shift_q, sda};
    assign byte_done = (state_q == SPW_RX) && scl_rise && (cnt_q == `SPW_BIT_LAST);
    // write only: a read address is not acknowledged
    assign addr_match = (rx_byte[7:2] == `SPW_ADDR_FIXED) && (rx_byte[1] == lvl[2])
        && !rx_byte[0]; // [RQ18] [RQ17]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SPW_IDLE;
            cnt_q <= 3'h0;
            shift_q <= 7'h00;
            ack_en_q <= 1'b0;
            ack_rise_q <= 1'b0;
            ack_drive_q <= 1'b0;
        end else if (start_det) begin
            // repeated start also lands here and restarts address reception
            state_q <= SPW_RX;
            cnt_q <= 3'h0;
            ack_rise_q <= 1'b0;
            ack_drive_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= SPW_IDLE;
            ack_drive_q <= 1'b0;
        end else begin
            case (state_q)
                SPW_RX: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte[6:0];
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == `SPW_BIT_LAST) begin
                            state_q <= SPW_ACK; // [RQ15]
                            ack_rise_q <= 1'b0;
                            ack_en_q <= (phase_q != SPW_PH_ADDR) || addr_match; // [RQ21]
                        end
                    end
                end
                SPW_ACK: begin
                    if (scl_fall && !ack_rise_q) begin
                        ack_drive_q <= ack_en_q; // [RQ16]
                    end else if (scl_rise) begin
                        ack_rise_q <= 1'b1;
                    end else if (scl_fall) begin
                        ack_drive_q <= 1'b0;
                        state_q <= ack_en_q ? SPW_RX : SPW_IDLE; // [RQ19] [RQ15]
                    end
                end
                default: begin
                    state_q <= SPW_IDLE;
                end
            endcase
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = ack_drive_q; // [RQ17]

    // byte framing: address, control, data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= SPW_PH_ADDR;
            route_q <= SPW_RT_NONE;
            more_q <= 1'b0;
            addressed_q <= 1'b0;
        end else if (start_det || stop_det) begin
            phase_q <= SPW_PH_ADDR; // [RQ20]
            addressed_q <= 1'b0;
        end else if (byte_done) begin
            case (phase_q)
                SPW_PH_ADDR: begin
                    if (addr_match) begin
                        phase_q <= SPW_PH_CTRL;
                        addressed_q <= 1'b1;
                    end
                end
                SPW_PH_CTRL: begin
                    more_q <= rx_byte[`SPW_CO_BIT]; // [RQ11]
                    route_q <= spw_route_type'(rx_byte[6:5]); // [RQ12]
                    phase_q <= SPW_PH_DATA;
                end
                SPW_PH_DATA: begin
                    if (more_q) begin
                        phase_q <= SPW_PH_CTRL; // [RQ13]
                    end
                end
                default: begin
                    phase_q <= SPW_PH_ADDR;
                end
            endcase
        end
    end

    logic data_byte;
    assign data_byte = byte_done && (phase_q == SPW_PH_DATA);

    // pwm pointer and pending channel values
    logic [2:0] ptr_q;
    logic [6:0] pending_q [NCH];
    function automatic logic [2:0] spw_ptr_next(input logic [2:0] p);
        spw_ptr_next = (p == 3'(NCH - 1)) ? 3'h0 : p + 3'h1;
    endfunction : spw_ptr_next

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_q <= 3'h0;
            for (int i = 0; i < NCH; i++) begin
                pending_q[i] <= 7'h00;
            end
        end else if (data_byte) begin
            if (route_q == SPW_RT_CMD && rx_byte[7:3] == `SPW_CMD_PTR_TAG) begin
                ptr_q <= ({1'b0, rx_byte[2:0]} < 4'(NCH)) ? rx_byte[2:0] : 3'h0; // [RQ2]
            end else if (route_q == SPW_RT_PWM) begin
                pending_q[ptr_q] <= rx_byte[6:0]; // [RQ2]
                ptr_q <= spw_ptr_next(ptr_q); // [RQ3]
            end
        end
    end

    // command and ram bytes handed on; route 11 bytes go nowhere
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_valid <= 1'b0;
            ram_valid <= 1'b0;
            cmd_data <= 8'h00;
            ram_data <= 8'h00;
        end else begin
            cmd_valid <= data_byte && (route_q == SPW_RT_CMD);
            ram_valid <= data_byte && (route_q == SPW_RT_RAM); // [RQ21]
            if (data_byte && route_q == SPW_RT_CMD) begin
                cmd_data <= rx_byte;
            end
            if (data_byte && route_q == SPW_RT_RAM) begin
                ram_data <= rx_byte;
            end
        end
    end

    // software registers
    logic inv_q;
    logic [15:0] slot_div_q;
    logic [NCH-1:0] gpo_en_q;
    logic [2*NCH-1:0] gpo_mode_q;

    // slot timing shared by all channels
    logic [15:0] div_cnt_q;
    logic [6:0] slot_q;
    logic [6:0] active_q [NCH];
    logic tick, frame_end;
    // >= keeps a shortened divider from running the count through 65535
    assign tick = (div_cnt_q >= slot_div_q); // [RQ22]
    assign frame_end = tick && (slot_q == `SPW_SLOT_MAX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= 16'h0000;
            slot_q <= 7'h00;
        end else begin
            div_cnt_q <= tick ? 16'h0000 : div_cnt_q + 16'h0001; // [RQ22]
            if (tick) begin
                slot_q <= slot_q + 7'h01; // [RQ6]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NCH; i++) begin
                active_q[i] <= 7'h00;
            end
        end else if (frame_end) begin
            for (int i = 0; i < NCH; i++) begin
                active_q[i] <= pending_q[i]; // [RQ23]
            end
        end
    end

    logic [NCH-1:0] mode_high;
    // one generator per channel, each from its own value and mode
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic wave;
        logic aux_d;
        assign mode_high[i] = (spw_gpo_mode_type'(gpo_mode_q[2*i +: 2]) == SPW_GM_HIGH);
        // slot 0 starts every frame, so plain waves rise together and inverted ones fall together
        assign wave = (slot_q < active_q[i]) ^ inv_q; // [RQ1] [RQ6] [RQ7] [RQ8] [RQ9] [RQ10]
        always_comb begin
            case (spw_gpo_mode_type'(gpo_mode_q[2*i +: 2]))
                SPW_GM_HIGH: aux_d = 1'b1; // [RQ5]
                SPW_GM_PWM: aux_d = wave; // [RQ5]
                default: aux_d = 1'b0; // [RQ5]
            endcase
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                aux_output_pins[i] <= 1'b0;
                segment_pins[i] <= 1'b0;
            end else begin
                aux_output_pins[i] <= aux_d;
                segment_pins[i] <= gpo_en_q[i] ? aux_d : segment_in[i]; // [RQ4]
            end
        end
    end

    // axi4-lite slave
    logic aw_have_q, w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    function automatic logic spw_pwm_hit(input logic [7:0] a);
        spw_pwm_hit = (a >= `SPW_REG_PWM_BASE) && (a < `SPW_REG_PWM_BASE + 8'(4 * NCH))
            && (a[1:0] == 2'h0);
    endfunction : spw_pwm_hit

    function automatic logic spw_mapped(input logic [7:0] a);
        spw_mapped = (a == `SPW_REG_CTRL) || (a == `SPW_REG_SLOTDIV) || (a == `SPW_REG_GPOEN)
            || (a == `SPW_REG_GPOMODE) || (a == `SPW_REG_STATUS) || spw_pwm_hit(a);
    endfunction : spw_mapped

    function automatic logic [31:0] spw_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        spw_merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                spw_merge[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction : spw_merge

    // byte lanes merged into each register's current value, bits above the field dropped
    logic [31:0] mrg_ctrl, mrg_div, mrg_en, mrg_mode;
    assign mrg_ctrl = spw_merge({31'h0, inv_q}, wdata_q, wstrb_q);
    assign mrg_div = spw_merge({16'h0, slot_div_q}, wdata_q, wstrb_q);
    assign mrg_en = spw_merge(32'(gpo_en_q), wdata_q, wstrb_q);
    assign mrg_mode = spw_merge(32'(gpo_mode_q), wdata_q, wstrb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPW_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= spw_mapped(awaddr_q) ? `SPW_RESP_OKAY : `SPW_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inv_q <= 1'b0;
            slot_div_q <= SLOTDIV_RST;
            gpo_en_q <= '0;
            gpo_mode_q <= '0;
        end else if (wr_fire) begin
            case (awaddr_q)
                `SPW_REG_CTRL: inv_q <= mrg_ctrl[`SPW_CTRL_INV_BIT]; // [RQ8]
                `SPW_REG_SLOTDIV: slot_div_q <= mrg_div[15:0];
                `SPW_REG_GPOEN: gpo_en_q <= mrg_en[NCH-1:0];
                `SPW_REG_GPOMODE: gpo_mode_q <= mrg_mode[2*NCH-1:0];
                default: begin
                end
            endcase
        end
    end

    logic [7:0] pwm_off;
    assign pwm_off = s_axi_araddr - `SPW_REG_PWM_BASE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= spw_mapped(s_axi_araddr) ? `SPW_RESP_OKAY : `SPW_RESP_SLVERR;
            if (spw_pwm_hit(s_axi_araddr)) begin
                s_axi_rdata <= {25'h0, pending_q[pwm_off[4:2]]};
            end else begin
                case (s_axi_araddr)
                    `SPW_REG_CTRL: s_axi_rdata <= {31'h0, inv_q};
                    `SPW_REG_SLOTDIV: s_axi_rdata <= {16'h0, slot_div_q};
                    `SPW_REG_GPOEN: s_axi_rdata <= 32'(gpo_en_q);
                    `SPW_REG_GPOMODE: s_axi_rdata <= 32'(gpo_mode_q);
                    `SPW_REG_STATUS: s_axi_rdata <= {17'h0, slot_q, 2'h0, addressed_q,
                        route_q, ptr_q};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic pwm_byte;
    assign pwm_byte = data_byte && (route_q == SPW_RT_PWM);

    a_ptr_store: assert property (pwm_byte |=> pending_q[$past(ptr_q)] == $past(rx_byte[6:0]))
        else $error("pwm byte not stored at pointer"); // [RQ2]
    a_ptr_wrap: assert property (pwm_byte |=> ptr_q == (($past(ptr_q) == 3'(NCH - 1)) ? 3'h0
        : $past(ptr_q) + 3'h1)) else $error("pointer did not advance or wrap"); // [RQ3]
    a_seg_override: assert property ($past(gpo_en_q[0]) |-> segment_pins[0] == aux_output_pins[0])
        else $error("segment pin not replaced by output"); // [RQ4]
    a_static_high: assert property (mode_high != '0 |=> // [RQ5]
        (aux_output_pins & $past(mode_high)) == $past(mode_high))
        else $error("static high mode not high");
    a_pwm_plain: assert property (gpo_mode_q[1:0] == SPW_GM_PWM && !inv_q |=>
        aux_output_pins[0] == ($past(slot_q) < $past(active_q[0])))
        else $error("plain pwm level wrong"); // [RQ6]
    a_zero_low: assert property (gpo_mode_q[1:0] == SPW_GM_PWM && !inv_q && active_q[0] == 7'h00
        |=> !aux_output_pins[0]) else $error("zero value not low"); // [RQ7]
    a_pwm_invert: assert property (gpo_mode_q[1:0] == SPW_GM_PWM && inv_q |=>
        aux_output_pins[0] == ($past(slot_q) >= $past(active_q[0])))
        else $error("inverted pwm level wrong"); // [RQ10]
    a_route_ctrl: assert property (byte_done && phase_q == SPW_PH_CTRL |=>
        route_q == spw_route_type'($past(rx_byte[6:5])) && phase_q == SPW_PH_DATA)
        else $error("control byte routing wrong"); // [RQ12]
    a_more_ctrl: assert property (data_byte && more_q |=> phase_q == SPW_PH_CTRL)
        else $error("continue flag ignored"); // [RQ13]
    a_start_rx: assert property (start_det |=> state_q == SPW_RX && cnt_q == 3'h0
        && phase_q == SPW_PH_ADDR) else $error("start not recognised"); // [RQ14]
    a_ack_stable: assert property (scl && $past(scl) |-> $stable(sda_oe))
        else $error("sda drive changed with scl high"); // [RQ16]
    a_only_ack: assert property (sda_oe |-> state_q == SPW_ACK && ack_en_q)
        else $error("sda driven outside acknowledge"); // [RQ17]
    a_addr_miss: assert property (byte_done && phase_q == SPW_PH_ADDR && !addr_match
        |=> !ack_en_q && phase_q == SPW_PH_ADDR) else $error("wrong address acknowledged"); // [RQ19]
    a_unused_drop: assert property (data_byte && route_q == SPW_RT_NONE |=> $stable(ptr_q)
        && !cmd_valid && !ram_valid) else $error("unused route byte had effect"); // [RQ21]
    a_frame_hold: assert property (!frame_end |=> $stable(active_q[0]))
        else $error("value changed mid frame"); // [RQ23]
    a_tick_reset: assert property (tick |=> div_cnt_q == 16'h0000)
        else $error("slot divider not restarted"); // [RQ22]

    c_addr_ack: cover property (byte_done && phase_q == SPW_PH_ADDR && addr_match);
    c_pwm_wrap: cover property (pwm_byte && ptr_q == 3'(NCH - 1));
    c_frame_end: cover property (frame_end);
    c_axi_write: cover property (wr_fire && awaddr_q == `SPW_REG_GPOMODE);
endmodule : spw_top

// *** verification/spw_host.sv ***
// two-wire bus master model driving the pwm block's serial port
`timescale 1ns/1ps
module spw_host (
    // clock
    input wire logic aclk,
    // bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // quarter bit time, 400 ns bit period at 50 ns clock
    task automatic q();
        repeat (2) @(posedge aclk);
    endtask : q
    // also serves as repeated start
    task automatic start();
        sda_pull <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask : start
    task automatic stop();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask : stop
    // data changes only while scl is low; ninth clock releases sda for ack
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_pull <= (i > 0) ? !b[i-1] : 1'b0;
            q();
            scl <= 1'b1;
            q();
            if (i == 0) ack = (sda === 1'b0);
            q();
            scl <= 1'b0;
            q();
        end
    endtask : send
endmodule : spw_host

// *** verification/spw_top_test.sv ***
// self-checking bench for the six-channel pwm block
`timescale 1ns/1ps
`include "spw_regs.svh"
module spw_top_test;
    import spw_pkg::*;
    localparam int DIV = 1;
    localparam int FRAME = 128 * (DIV + 1);
    logic aclk, aresetn, awv, wv, br, arv, rr, scl, pull, ack, asel;
    logic [7:0] awa, ara, cmdd, ramd;
    logic [31:0] wd;
    logic [5:0] seg_in, seg, aux;
    logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, sda_oe;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    wire logic sda = !(sda_oe | pull);
    int n_mismatch, comparisons, sm;
    int cnt[6];
    int v[6] = '{5, 0, 16, 32, 48, 127};
    int md[6] = '{2, 1, 2, 2, 0, 2};
    logic [7:0] s1[9] = '{8'h70, 8'h80, 8'hEA, 8'h40, 8'h10, 8'h20, 8'h30, 8'h7F, 8'h85};
    spw_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rr), .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .address_select_pin(asel),
        .cmd_valid(), .cmd_data(cmdd), .ram_valid(), .ram_data(ramd), .segment_in(seg_in),
        .segment_pins(seg), .aux_output_pins(aux));
    spw_host i_host (.aclk(aclk), .sda(sda), .scl(scl), .sda_pull(pull));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // handshakes are sampled at the falling edge so the rising edge never races
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        logic [1:0] r;
        tb = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = awv && aw_rdy;
            tw = wv && w_rdy;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        chk("bresp", `SPW_RESP_OKAY, r);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        tr = 1'b0;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = arv && ar_rdy;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arv <= 1'b0;
        end
        chk("rdata", e, d & m);
        chk("rresp", er, r);
    endtask : rdc
    task automatic xfer(input logic [7:0] b, input logic e);
        i_host.send(b, ack);
        chk("ack", e, ack);
    endtask : xfer
    // duty is phase independent over a whole frame, so no frame alignment is needed
    task automatic measure(input bit inv);
        cnt = '{default: 0};
        sm = 0;
        repeat (FRAME) begin
            @(negedge aclk);
            for (int i = 0; i < 6; i++) cnt[i] += aux[i];
            sm += (seg !== aux);
        end
        @(posedge aclk);
        chk("segment_pins", 0, sm);
        for (int i = 0; i < 6; i++) begin
            if (md[i] != 2) chk("aux_high", md[i] * FRAME, cnt[i]);
            else if (inv) chk("aux_high", (128 - v[i]) * (DIV + 1), cnt[i]);
            else chk("aux_high", v[i] * (DIV + 1), cnt[i]);
        end
    endtask : measure
    initial begin
        logic [31:0] gm;
        gm = 32'h0;
        for (int i = 0; i < 6; i++) gm |= 32'(md[i]) << (2 * i);
        {aresetn, awv, wv, br, arv, rr} = 6'h00;
        awa = 8'h00;
        ara = 8'h00;
        wd = 32'h0;
        seg_in = 6'h2A;
        asel = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wr(`SPW_REG_SLOTDIV, DIV);
        chk("segment_pins", seg_in, seg);
        wr(`SPW_REG_GPOEN, 32'h3F);
        wr(`SPW_REG_GPOMODE, gm);
        i_host.start();
        foreach (s1[k]) xfer(s1[k], 1'b1);
        i_host.stop();
        i_host.start();
        xfer(8'h71, 1'b0);
        i_host.start();
        xfer(8'h72, 1'b0);
        xfer(8'h40, 1'b0);
        xfer(8'h0F, 1'b0);
        i_host.start();
        xfer(8'h70, 1'b1);
        xfer(8'hE0, 1'b1);
        xfer(8'h11, 1'b1);
        xfer(8'h20, 1'b1);
        xfer(8'h5A, 1'b1);
        i_host.stop();
        chk("cmd_data", 8'hEA, cmdd);
        chk("ram_data", 8'h5A, ramd);
        asel <= 1'b1;
        i_host.start();
        xfer(8'h70, 1'b0);
        i_host.start();
        xfer(8'h72, 1'b1);
        i_host.stop();
        for (int i = 0; i < 6; i++) rdc(8'(`SPW_REG_PWM_BASE + 4 * i), 32'h7F, v[i], 2'h0);
        rdc(`SPW_REG_STATUS, 32'h7, 32'h1, `SPW_RESP_OKAY);
        rdc(8'h40, 32'hFFFFFFFF, 32'h0, `SPW_RESP_SLVERR);
        repeat (2 * FRAME) @(posedge aclk);
        measure(1'b0);
        wr(`SPW_REG_CTRL, 32'h1);
        repeat (2 * FRAME) @(posedge aclk);
        measure(1'b1);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        give_verdict();
    end
endmodule : spw_top_test
